// ### verilog/fpdp_cfg.svh
/*
 Opcodes, widths and timing figures for the protection command block.
 Assumes inclusion by bare name from files under verilog/.
*/
`ifndef FPDP_CFG_SVH
`define FPDP_CFG_SVH
`define FPDP_OP_WREN 8'h06
`define FPDP_OP_GLOCK 8'h7e
`define FPDP_OP_GUNLOCK 8'h98
`define FPDP_OP_RDPWD 8'h27
`define FPDP_OP_WRPWD 8'h28
`define FPDP_OP_PWUNLK 8'h29
`define FPDP_OP_BITS 7'h08
`define FPDP_PWD_BITS 7'h40
`define FPDP_FRAME_BITS 7'h48
`define FPDP_CLK_MHZ 10
`define FPDP_UNLOCK_NS 2000
`define FPDP_UNLOCK_CYC ((`FPDP_UNLOCK_NS * `FPDP_CLK_MHZ + 999) / 1000)
`define FPDP_PWD_RESET 64'hffff_ffff_ffff_ffff
`define FPDP_SYNC_IDLE 6'h01
`endif

// ### verilog/fpdp_pkg.sv
/*
 Types shared by the protection command block.
 Assumes fpdp_cfg.svh is available on the include path.
*/
package fpdp_pkg;
   // Frame decoder states
   typedef enum logic [2:0] {
      FPDP_IDLE, FPDP_OPCODE, FPDP_DATA_IN, FPDP_DATA_OUT, FPDP_IGNORE
   } fpdp_state_t;
   // Pending command kinds
   typedef enum logic [1:0] {
      FPDP_CMD_NONE, FPDP_CMD_WRPWD, FPDP_CMD_PWUNLK
   } fpdp_cmd_t;
endpackage : fpdp_pkg

// ### verilog/fpdp_pin_if.sv
/*
 Carrier for synchronised serial pin events between the front end and core.
 Assumes one clock domain, clk_sys.
*/
`timescale 1ns/1ps
interface fpdp_pin_if;
   logic cs_act; // Chip select asserted
   logic rise; // Serial clock rising edge pulse
   logic fall; // Serial clock falling edge pulse
   logic cs_end; // Chip select release pulse
   logic [3:0] din; // Data lines, synchronised
   modport front (output cs_act, rise, fall, cs_end, din);
   modport core (input cs_act, rise, fall, cs_end, din);
endinterface : fpdp_pin_if

// ### verilog/fpdp_pin_sync.sv
/*
 Two-flop synchronisers and edge pulses for the serial pins.
 Assumes pin inputs are asynchronous to clk_sys and much slower than it.
*/
`timescale 1ns/1ps
`include "fpdp_cfg.svh"
module fpdp_pin_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // Raw pins
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] dq_pin,
   // Synchronised events
   fpdp_pin_if.front pin
);
   logic [5:0] s1_q; // First stage, read only by second
   logic [5:0] s2_q; // Second stage
   logic [5:0] s3_q; // Previous value for edges

   // Synchroniser chain; chip select idles high
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= `FPDP_SYNC_IDLE;
         s2_q <= `FPDP_SYNC_IDLE;
         s3_q <= `FPDP_SYNC_IDLE;
      end else if (clk_en) begin
         s1_q <= {dq_pin, sclk_pin, cs_n_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Edge pulses are gated by enable
   assign pin.cs_act = ~s2_q[0];
   assign pin.rise = clk_en & s2_q[1] & ~s3_q[1] & ~s2_q[0];
   assign pin.fall = clk_en & ~s2_q[1] & s3_q[1] & ~s2_q[0];
   assign pin.cs_end = clk_en & s2_q[0] & ~s3_q[0];
   assign pin.din = s2_q[5:2];
endmodule : fpdp_pin_sync

// ### verilog/fpdp_core.sv
/*
 Protection command interpreter: global dynamic lock and unlock, password
 read, write and unlock, persistent-bit lock latch.
 Assumes serial pins arrive asynchronously and are oversampled by clk_sys.
*/
// What this block does
// - Global lock with latch sets all dynamic bits
// - Lock frame: select, opcode, deselect
// - Global unlock with latch clears dynamic bits
// - Unlock frame: select, opcode, deselect executes
// - Password read shifts out msb first, falling
// - Password write stores 64 bits at deselect
// - Matching password sets persistent-bit lock latch
// - Latch clears on every reset
// - Persistent bit changes refused while latch clear
// - Unlock takes effect after two microseconds
// - Busy flag clears when unlock completes
// - Unlock frame: opcode plus 64 bits
// - Locked regions refuse program and erase
// - Dynamic bits set after every reset
`timescale 1ns/1ps
`include "fpdp_cfg.svh"
module fpdp_core import fpdp_pkg::*; #(
   parameter int NUM_REGIONS = 512,
   parameter int UNLOCK_CYC = `FPDP_UNLOCK_CYC
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // Serial pins
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] dq_pin,
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe,
   // Mode and status
   input wire logic quad_command_mode,
   output logic write_enable_latch,
   output logic write_in_progress_flag,
   output logic persistent_bit_lock_latch,
   output logic [NUM_REGIONS-1:0] dynamic_sector_lock_bit,
   // Program/erase and persistent bit requests from the array side
   input wire logic [$clog2(NUM_REGIONS)-1:0] pe_region,
   input wire logic pe_req,
   output logic pe_allow,
   input wire logic persist_mod_req,
   output logic persist_mod_allow
);
   fpdp_pin_if pin ();
   fpdp_state_t state_q;
   fpdp_cmd_t cmd_q;
   logic [6:0] bit_cnt_q; // Bits taken in this frame
   logic [7:0] opcode_q; // Opcode shift register
   logic [63:0] shift_q; // Password data in
   logic [63:0] password_q; // Stored password
   logic [63:0] out_q; // Read shifter
   logic [31:0] wait_q; // Unlock delay counter
   logic [3:0] dq_out_q;
   logic oe_q;
   logic [2:0] step;
   logic [63:0] op_next; // Opcode word after this rise

   fpdp_pin_sync u_sync (
      .clk_sys (clk_sys),
      .arst_n (arst_n),
      .clk_en (clk_en),
      .cs_n_pin (cs_n_pin),
      .sclk_pin (sclk_pin),
      .dq_pin (dq_pin),
      .pin (pin)
   );

   // Bits per clock edge: one or four lines
   assign step = quad_command_mode ? 3'h4 : 3'h1;

   // Shift new bits into a word, msb first
   function automatic logic [63:0] shift_in(input logic [63:0] w,
      input logic [3:0] d, input logic quad);
      shift_in = quad ? {w[59:0], d} : {w[62:0], d[0]};
   endfunction : shift_in

   // Opcode as it will stand after the current rise; read twice below
   assign op_next = shift_in({56'h0, opcode_q}, pin.din, quad_command_mode);

   // Frame decoder
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= FPDP_IDLE;
         bit_cnt_q <= 7'h00;
         opcode_q <= 8'h00;
      end else if (clk_en) begin
         if (pin.cs_end || !pin.cs_act) begin
            state_q <= FPDP_IDLE;
            bit_cnt_q <= 7'h00;
         end else if (pin.rise) begin
            bit_cnt_q <= bit_cnt_q + 7'(step);
            unique case (state_q)
               FPDP_IDLE, FPDP_OPCODE: begin
                  opcode_q <= op_next[7:0];
                  state_q <= FPDP_OPCODE;
                  if (bit_cnt_q + 7'(step) == `FPDP_OP_BITS) begin
                     // Last opcode bits decide read or write direction
                     if (op_next[7:0] == `FPDP_OP_RDPWD)
                        state_q <= FPDP_DATA_OUT;
                     else
                        state_q <= FPDP_DATA_IN;
                  end
               end
               FPDP_DATA_IN: begin
                  if (bit_cnt_q + 7'(step) == `FPDP_FRAME_BITS)
                     state_q <= FPDP_IGNORE;
               end
               FPDP_DATA_OUT, FPDP_IGNORE: begin
               end
               default: state_q <= FPDP_IGNORE;
            endcase
         end
      end
   end

   // Password bits in
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         shift_q <= 64'h0;
      else if (clk_en && pin.rise && state_q == FPDP_DATA_IN)
         shift_q <= shift_in(shift_q, pin.din, quad_command_mode);
   end

   // Read shifter: reload from password while selected and not in the read state, drive on falling edges
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         out_q <= 64'h0;
         dq_out_q <= 4'h0;
         oe_q <= 1'b0;
      end else if (clk_en) begin
         if (!pin.cs_act) begin
            oe_q <= 1'b0;
         end else if (state_q == FPDP_DATA_OUT && pin.fall) begin
            oe_q <= 1'b1;
            if (quad_command_mode) begin
               dq_out_q <= out_q[63:60];
               out_q <= {out_q[59:0], out_q[63:60]};
            end else begin
               dq_out_q <= {3'h0, out_q[63]}; // Mirror onto output line
               out_q <= {out_q[62:0], out_q[63]};
            end
         end else if (state_q != FPDP_DATA_OUT) begin
            out_q <= password_q;
         end
      end
   end
   assign dq_out = quad_command_mode ? dq_out_q : {2'h0, dq_out_q[0], 1'b0};
   assign dq_oe = quad_command_mode ? {4{oe_q}} : {2'h0, oe_q, 1'b0};

   // Write enable latch, dynamic bits and stored password
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         write_enable_latch <= 1'b0;
         dynamic_sector_lock_bit <= '1;
         password_q <= `FPDP_PWD_RESET;
         cmd_q <= FPDP_CMD_NONE;
      end else if (clk_en) begin
         cmd_q <= FPDP_CMD_NONE;
         if (pin.cs_end && bit_cnt_q == `FPDP_OP_BITS) begin
            if (opcode_q == `FPDP_OP_WREN)
               write_enable_latch <= 1'b1;
            else if (write_enable_latch) begin
               if (opcode_q == `FPDP_OP_GLOCK) begin
                  dynamic_sector_lock_bit <= '1;
                  write_enable_latch <= 1'b0;
               end else if (opcode_q == `FPDP_OP_GUNLOCK) begin
                  dynamic_sector_lock_bit <= '0;
                  write_enable_latch <= 1'b0;
               end
            end
         end else if (pin.cs_end && bit_cnt_q == `FPDP_FRAME_BITS &&
            write_enable_latch) begin
            // Only the two data commands use up the write enable
            if (opcode_q == `FPDP_OP_WRPWD) begin
               password_q <= shift_q;
               write_enable_latch <= 1'b0;
            end else if (opcode_q == `FPDP_OP_PWUNLK) begin
               cmd_q <= FPDP_CMD_PWUNLK;
               write_enable_latch <= 1'b0;
            end
         end
      end
   end

   // Password unlock: busy for the delay, then latch on a match
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         persistent_bit_lock_latch <= 1'b0;
         write_in_progress_flag <= 1'b0;
         wait_q <= 32'h0;
      end else if (clk_en) begin
         if (cmd_q == FPDP_CMD_PWUNLK && shift_q == password_q) begin
            write_in_progress_flag <= 1'b1;
            wait_q <= 32'(UNLOCK_CYC);
            // Wrong password: no busy period, latch kept
         end else if (cmd_q == FPDP_CMD_PWUNLK) begin
            write_in_progress_flag <= 1'b0;
         end else if (write_in_progress_flag) begin
            if (wait_q <= 32'h1) begin
               persistent_bit_lock_latch <= 1'b1;
               write_in_progress_flag <= 1'b0;
            end
            wait_q <= wait_q - 32'h1;
         end
      end
   end

   // Protection gates toward the array
   assign pe_allow = pe_req & ~dynamic_sector_lock_bit[pe_region];
   assign persist_mod_allow = persist_mod_req & persistent_bit_lock_latch;
endmodule : fpdp_core

// ### verif/fpdp_host_model.sv
/* Host serial model that frames commands into the block.
   Assumes clk_sys from the bench; pins change on its falling edge. */
`timescale 1ns/1ps
module fpdp_host_model (
   // Clock and mode
   input wire logic clk_sys,
   input wire logic quad,
   // Serial pins
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic [3:0] dq_pin,
   input wire logic [3:0] dq_out
);
   // Deselected, serial clock standing still
   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      dq_pin = 4'h5;
   end
   // Half a serial period, slow enough for the synchronisers
   task automatic half();
      repeat (5) @(negedge clk_sys);
   endtask : half
   // Opcode, nd data bits, then an optional 64-bit read
   task automatic xfer(input logic [7:0] op, input logic [63:0] d,
         input int nd, input bit rd, output logic [63:0] q);
      logic [71:0] sh;
      sh = {op, d};
      q = '0;
      @(negedge clk_sys);
      cs_n_pin = 1'b0;
      repeat ((8 + nd) / (quad ? 4 : 1)) begin
         dq_pin = quad ? sh[71:68] : {~dq_pin[3:1], sh[71]};
         half();
         sclk_pin = 1'b1;
         half();
         sclk_pin = 1'b0;
         sh = quad ? sh << 4 : sh << 1;
      end
      // Read bits sampled late in the low phase
      if (rd) repeat (quad ? 16 : 64) begin
         dq_pin = ~dq_pin;
         half();
         q = quad ? {q[59:0], dq_out} : {q[62:0], dq_out[1]};
         sclk_pin = 1'b1;
         half();
         sclk_pin = 1'b0;
      end
      half();
      cs_n_pin = 1'b1;
      dq_pin = ~dq_pin; // Released lines keep moving
      repeat (30) @(negedge clk_sys);
   endtask : xfer
endmodule : fpdp_host_model

// ### verif/fpdp_core_chk.sv
/* Port-level checks on the protection command block.
   Assumes binding to fpdp_core; one clock, async active-low reset. */
`timescale 1ns/1ps
module fpdp_core_chk #(
   parameter int NUM_REGIONS = 512,
   parameter int UNLOCK_CYC = 20
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Pins and mode
   input wire logic cs_n_pin,
   input wire logic [3:0] dq_oe,
   input wire logic quad_command_mode,
   // Status
   input wire logic write_enable_latch,
   input wire logic write_in_progress_flag,
   input wire logic persistent_bit_lock_latch,
   input wire logic [NUM_REGIONS-1:0] dynamic_sector_lock_bit,
   // Array side
   input wire logic [$clog2(NUM_REGIONS)-1:0] pe_region,
   input wire logic pe_req,
   input wire logic pe_allow,
   input wire logic persist_mod_req,
   input wire logic persist_mod_allow
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Cycles spent busy so far
   int busy_cnt_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) busy_cnt_q <= 0;
      else if (write_in_progress_flag) busy_cnt_q <= busy_cnt_q + 1;
      else busy_cnt_q <= 0;
   end
   sequence s_busy; $rose(write_in_progress_flag); endsequence
   sequence s_done; !write_in_progress_flag && persistent_bit_lock_latch;
   endsequence
   property p_pe; pe_allow == (pe_req && !dynamic_sector_lock_bit[pe_region]);
   endproperty
   a_pe: assert property (p_pe) else $error("program allow wrong");
   property p_pm; persist_mod_allow == (persist_mod_req &&
      persistent_bit_lock_latch); endproperty
   a_pm: assert property (p_pm) else $error("persist allow wrong");
   property p_rst; $rose(arst_n) |-> &dynamic_sector_lock_bit &&
      !persistent_bit_lock_latch && !write_in_progress_flag; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_wait; $rose(persistent_bit_lock_latch) |->
      busy_cnt_q >= UNLOCK_CYC; endproperty
   a_wait: assert property (p_wait) else $error("unlock too early");
   property p_end; s_busy |-> ##[1:1000] s_done; endproperty
   a_end: assert property (p_end) else $error("busy never ends");
   property p_all; $changed(dynamic_sector_lock_bit) |->
      (&dynamic_sector_lock_bit || dynamic_sector_lock_bit == '0); endproperty
   a_all: assert property (p_all) else $error("partial lock change");
   property p_wel; (!write_enable_latch)[*8] |=>
      $stable(dynamic_sector_lock_bit); endproperty
   a_wel: assert property (p_wel) else $error("change without enable");
   property p_idle; cs_n_pin[*8] |-> dq_oe == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("drive while idle");
   property p_one; !quad_command_mode |-> dq_oe[3:2] == 2'b00 && !dq_oe[0];
   endproperty
   a_one: assert property (p_one) else $error("single mode drive");
endmodule : fpdp_core_chk
bind fpdp_core fpdp_core_chk #(.NUM_REGIONS(NUM_REGIONS),
   .UNLOCK_CYC(UNLOCK_CYC)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
   .cs_n_pin(cs_n_pin), .dq_oe(dq_oe), .quad_command_mode(quad_command_mode),
   .write_enable_latch(write_enable_latch),
   .write_in_progress_flag(write_in_progress_flag),
   .persistent_bit_lock_latch(persistent_bit_lock_latch),
   .dynamic_sector_lock_bit(dynamic_sector_lock_bit), .pe_region(pe_region),
   .pe_req(pe_req), .pe_allow(pe_allow), .persist_mod_req(persist_mod_req),
   .persist_mod_allow(persist_mod_allow));

// ### verif/tb_flash_password_dynamic_protect.sv
/* Self-checking bench for the protection command block.
   Assumes fpdp_core driven by the host model; small counts. */
`timescale 1ns/1ps
module tb_flash_password_dynamic_protect;
   localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic quad = 1'b0;
   logic pe_req = 1'b0;
   logic pm_req = 1'b0;
   logic [3:0] region = 4'h0;
   logic clk_en = 1'b1;
   logic cs_n, sclk, we_lat, busy, plat, pe_ok, pm_ok;
   logic [3:0] dq, dq_out, dq_oe;
   logic [15:0] dyn;
   logic [63:0] rd;
   int miscompares = 0;
   int total_checks = 0;
   // Row: enable first, opcode, data, bits, quad, expected
   typedef struct {bit wr; logic [7:0] op; logic [63:0] d; int nd;
      bit q; logic dyn; logic lat;} fpdp_row_t;
   fpdp_row_t rows [8] = '{'{1, 8'h98, 0, 0, 0, 0, 0},
      '{1, 8'h7e, 0, 0, 1, 1, 0}, '{0, 8'h98, 0, 0, 0, 1, 0},
      '{1, 8'h98, 0, 0, 1, 0, 0}, '{0, 8'h7e, 0, 0, 0, 0, 0},
      '{1, 8'h28, PW, 64, 1, 0, 0}, '{1, 8'h29, ~PW, 64, 0, 0, 0},
      '{1, 8'h29, PW, 64, 1, 0, 1}};
   always #50 clk_sys = ~clk_sys;
   fpdp_host_model u_host (.clk_sys(clk_sys), .quad(quad), .cs_n_pin(cs_n),
      .sclk_pin(sclk), .dq_pin(dq), .dq_out(dq_out));
   fpdp_core #(.NUM_REGIONS(16), .UNLOCK_CYC(3)) DUT (.clk_sys(clk_sys),
      .arst_n(arst_n), .clk_en(clk_en), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .dq_pin(dq), .dq_out(dq_out), .dq_oe(dq_oe), .quad_command_mode(quad),
      .write_enable_latch(we_lat), .write_in_progress_flag(busy),
      .persistent_bit_lock_latch(plat), .dynamic_sector_lock_bit(dyn),
      .pe_region(region), .pe_req(pe_req), .pe_allow(pe_ok),
      .persist_mod_req(pm_req), .persist_mod_allow(pm_ok));
   // Compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Verdict and end of run
   task automatic summarize();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // Optional write enable frame, then the command frame
   task automatic cmd(input bit wr, input logic [7:0] op,
         input logic [63:0] d, input int nd, input bit q);
      quad = q;
      if (wr) u_host.xfer(8'h06, 64'h0, 0, 0, rd);
      u_host.xfer(op, d, nd, 0, rd);
   endtask : cmd
   // Reset pulse of n cycles
   task automatic do_reset(input int n);
      arst_n = 1'b0;
      repeat (n) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
   endtask : do_reset
   initial begin
      do_reset(6);
      chk(64'({plat, busy, we_lat}), 0);
      chk(64'(dyn), 64'hffff);
      foreach (rows[i]) begin
         cmd(rows[i].wr, rows[i].op, rows[i].d, rows[i].nd, rows[i].q);
         chk(64'(dyn), rows[i].dyn ? 64'hffff : 0);
         chk(64'(plat), 64'(rows[i].lat));
         chk(64'({we_lat, busy}), 0);
      end
      // Password read back, single line, msb first
      quad = 1'b0;
      u_host.xfer(8'h27, 64'h0, 0, 1, rd);
      chk(rd, PW);
      // Same read on four lines, nibble by nibble
      quad = 1'b1;
      u_host.xfer(8'h27, 64'h0, 0, 1, rd);
      chk(rd, PW);
      // Array side requests, region unlocked then locked again
      pe_req = 1'b1;
      pm_req = 1'b1;
      region = 4'h3;
      @(negedge clk_sys);
      chk(64'({pe_ok, pm_ok}), 64'h3);
      cmd(1, 8'h7e, 64'h0, 0, 0);
      chk(64'(pe_ok), 0);
      // Reset mid-run drops the latch and restores defaults
      do_reset(2);
      chk(64'({plat, pm_ok, busy}), 0);
      chk(64'(dyn), 64'hffff);
      // Password write without enable is ignored
      cmd(0, 8'h28, PW, 64, 0);
      u_host.xfer(8'h27, 64'h0, 0, 1, rd);
      chk(rd, 64'hffff_ffff_ffff_ffff);
      // A frame sent while the enable is low leaves no trace
      u_host.xfer(8'h06, 64'h0, 0, 0, rd);
      clk_en = 1'b0;
      u_host.xfer(8'h98, 64'h0, 0, 0, rd);
      clk_en = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(64'({we_lat, dyn}), 64'h1_ffff);
      u_host.xfer(8'h98, 64'h0, 0, 0, rd);
      chk(64'(dyn), 0);
      summarize();
   end
endmodule : tb_flash_password_dynamic_protect
